// [shared/iosnf_pkg.sv]
// constants for the sample / node-id frame emitter
// assumes a byte-wide serial transmitter with valid/ready on the far side
package iosnf_pkg;

  localparam logic [7:0] START_DELIM     = 8'h7e;
  localparam logic [7:0] TYPE_IO_SAMPLE  = 8'h92;
  localparam logic [7:0] TYPE_NODE_ID    = 8'h95;
  localparam logic [7:0] SAMPLE_SETS     = 8'h01;
  localparam logic [7:0] RESERVED_HI     = 8'hff;
  localparam logic [7:0] RESERVED_LO     = 8'hfe;
  localparam logic [7:0] TEXT_TERM       = 8'h00;
  localparam logic [7:0] CSUM_BASE       = 8'hff;
  localparam logic [7:0] RXOPT_ACK       = 8'h01;
  localparam logic [7:0] RXOPT_BCAST     = 8'h02;
  localparam logic [7:0] RXOPT_MODE_MASK = 8'hc0;
  localparam logic [7:0] RXOPT_IO_MASK   = 8'h03;
  localparam logic [7:0] RXOPT_NI_MASK   = 8'hc3;
  localparam int unsigned NI_TEXT_MAX    = 20;
  localparam int unsigned AN_CHANS       = 5;

  // byte positions counted from the start delimiter
  localparam logic [6:0] OFS_LEN_MSB     = 7'h01;
  localparam logic [6:0] OFS_TYPE        = 7'h03;
  localparam logic [6:0] OFS_ADDR64      = 7'h04;
  localparam logic [6:0] OFS_IO_NET16    = 7'h0c;
  localparam logic [6:0] OFS_RXOPT       = 7'h0e;
  localparam logic [6:0] OFS_IO_NSETS    = 7'h0f;
  localparam logic [6:0] OFS_IO_DMASK    = 7'h10;
  localparam logic [6:0] OFS_IO_AMASK    = 7'h12;
  localparam logic [6:0] OFS_IO_DSAMP    = 7'h13;
  localparam logic [6:0] OFS_NI_REMOTE   = 7'h11;
  localparam logic [6:0] OFS_NI_TEXT     = 7'h19;

  typedef enum logic [2:0] {
    IOSNF_IDLE = 3'b000,
    IOSNF_HEAD = 3'b001,
    IOSNF_BODY = 3'b011,
    IOSNF_CSUM = 3'b010
  } iosnf_state_t;

endpackage : iosnf_pkg

// [hdl/iosnf_emitter.sv]
// serialises one received-indication frame per request onto a byte stream
// assumes the request data is held stable until req is accepted;
// the serial transmitter downstream stalls via tx_ready_i
`timescale 1ns/1ps
module iosnf_emitter (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // configuration
  input  wire logic        api_output_format_select_i,
  input  wire logic        disc_opt_dev_type_en_i,
  input  wire logic        disc_opt_rssi_en_i,
  // I/O sample request
  input  wire logic        io_req_i,
  output logic             io_ack_o,
  input  wire logic [63:0] io_src_addr64_i,
  input  wire logic [15:0] io_src_net16_i,
  input  wire logic [7:0]  io_rx_opts_i,
  input  wire logic [15:0] io_digital_io_line_mask_i,
  input  wire logic [7:0]  io_analog_mask_i,
  input  wire logic [15:0] io_digital_samples_i,
  input  wire logic [79:0] io_analog_samples_i,
  // node identification request
  input  wire logic        ni_req_i,
  output logic             ni_ack_o,
  input  wire logic [63:0] ni_src_addr64_i,
  input  wire logic [7:0]  ni_rx_opts_i,
  input  wire logic [63:0] ni_remote_addr64_i,
  input  wire logic [159:0] node_identifier_text_i,
  input  wire logic [4:0]  ni_text_len_i,
  input  wire logic [7:0]  ni_dev_type_i,
  input  wire logic [7:0]  ni_src_event_i,
  input  wire logic [15:0] ni_profile_id_i,
  input  wire logic [15:0] ni_manuf_id_i,
  input  wire logic [31:0] device_type_identifier_i,
  input  wire logic [7:0]  ni_rssi_i,
  // byte stream to the host serial port, plus busy and frame-done status
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  output logic             busy_o,
  output logic             frame_done_o
);

  // the whole frame is assembled into a byte array when a request is taken,
  // trading area for a trivially simple shifter and running checksum;
  // sized for a full-length identifier text with both optional fields
  localparam int unsigned FRAME_MAX = 64;

  typedef struct packed {
    iosnf_pkg::iosnf_state_t state;
    logic [FRAME_MAX-1:0][7:0] buf_bytes;
    logic [6:0]                idx;
    logic [6:0]                last;
    logic [7:0]                sum;
    logic [7:0]                tx_data;
    logic                      done;
  } iosnf_regs_t;

  iosnf_regs_t r;
  iosnf_regs_t next_r;

  logic                      take_io;
  logic                      take_ni;
  logic [FRAME_MAX-1:0][7:0] io_img;
  logic [FRAME_MAX-1:0][7:0] ni_img;
  logic [6:0]                io_len;
  logic [6:0]                ni_len;

  // the format select decides which kind is taken (io when set, ni when clear); each request is held until ack
  assign take_io  = (r.state == iosnf_pkg::IOSNF_IDLE) && io_req_i
                    && api_output_format_select_i;
  assign take_ni  = (r.state == iosnf_pkg::IOSNF_IDLE) && ni_req_i && !take_io
                    && !api_output_format_select_i;
  assign io_ack_o = take_io;
  assign ni_ack_o = take_ni;

  // I/O sample frame image, returns position after last data byte
  always_comb begin
    logic [6:0] p;
    p      = 7'h00;
    io_img = '0;
    io_img[iosnf_pkg::OFS_TYPE] = iosnf_pkg::TYPE_IO_SAMPLE;
    for (int i = 0; i < 8; i++) begin
      io_img[iosnf_pkg::OFS_ADDR64 + 7'(i)] = io_src_addr64_i[63-8*i -: 8];
    end
    io_img[iosnf_pkg::OFS_IO_NET16]        = io_src_net16_i[15:8];
    io_img[iosnf_pkg::OFS_IO_NET16 + 7'h1] = io_src_net16_i[7:0];
    io_img[iosnf_pkg::OFS_RXOPT]  = io_rx_opts_i & iosnf_pkg::RXOPT_IO_MASK;
    io_img[iosnf_pkg::OFS_IO_NSETS] = iosnf_pkg::SAMPLE_SETS;
    io_img[iosnf_pkg::OFS_IO_DMASK]        = io_digital_io_line_mask_i[15:8];
    io_img[iosnf_pkg::OFS_IO_DMASK + 7'h1] = io_digital_io_line_mask_i[7:0];
    io_img[iosnf_pkg::OFS_IO_AMASK] = io_analog_mask_i;
    p = iosnf_pkg::OFS_IO_DSAMP;
    if (io_digital_io_line_mask_i != 16'h0000) begin
      io_img[p]        = io_digital_samples_i[15:8] & io_digital_io_line_mask_i[15:8];
      io_img[p + 7'h1] = io_digital_samples_i[7:0] & io_digital_io_line_mask_i[7:0];
      p = p + 7'h2;
    end
    // bit 7 of the analog mask selects the supply reading, emitted last
    for (int c = 0; c < int'(iosnf_pkg::AN_CHANS); c++) begin
      if (io_analog_mask_i[(c == 4) ? 7 : c]) begin
        io_img[p]        = io_analog_samples_i[16*c+8 +: 8];
        io_img[p + 7'h1] = io_analog_samples_i[16*c +: 8];
        p = p + 7'h2;
      end
    end
    io_len = p;
  end

  // node identification frame image
  always_comb begin
    logic [6:0] q;
    logic       live;
    q      = 7'h00;
    live   = 1'b1;
    ni_img = '0;
    ni_img[iosnf_pkg::OFS_TYPE] = iosnf_pkg::TYPE_NODE_ID;
    for (int i = 0; i < 8; i++) begin
      ni_img[iosnf_pkg::OFS_ADDR64 + 7'(i)]    = ni_src_addr64_i[63-8*i -: 8];
      ni_img[iosnf_pkg::OFS_NI_REMOTE + 7'(i)] = ni_remote_addr64_i[63-8*i -: 8];
    end
    ni_img[iosnf_pkg::OFS_RXOPT - 7'h2] = iosnf_pkg::RESERVED_HI;
    ni_img[iosnf_pkg::OFS_RXOPT - 7'h1] = iosnf_pkg::RESERVED_LO;
    ni_img[iosnf_pkg::OFS_RXOPT] = ni_rx_opts_i & iosnf_pkg::RXOPT_NI_MASK;
    ni_img[iosnf_pkg::OFS_RXOPT + 7'h1] = iosnf_pkg::RESERVED_HI;
    ni_img[iosnf_pkg::OFS_RXOPT + 7'h2] = iosnf_pkg::RESERVED_LO;
    q = iosnf_pkg::OFS_NI_TEXT;
    // text stops at the given length or at an embedded zero, whichever first
    for (int k = 0; k < int'(iosnf_pkg::NI_TEXT_MAX); k++) begin
      if (live && (5'(k) < ni_text_len_i)
          && (node_identifier_text_i[159-8*k -: 8] != iosnf_pkg::TEXT_TERM)) begin
        ni_img[q] = node_identifier_text_i[159-8*k -: 8];
        q = q + 7'h1;
      end else begin
        live = 1'b0;
      end
    end
    ni_img[q]        = iosnf_pkg::TEXT_TERM;
    ni_img[q + 7'h1] = iosnf_pkg::RESERVED_HI;
    ni_img[q + 7'h2] = iosnf_pkg::RESERVED_LO;
    ni_img[q + 7'h3] = ni_dev_type_i;
    ni_img[q + 7'h4] = ni_src_event_i;
    ni_img[q + 7'h5] = ni_profile_id_i[15:8];
    ni_img[q + 7'h6] = ni_profile_id_i[7:0];
    ni_img[q + 7'h7] = ni_manuf_id_i[15:8];
    ni_img[q + 7'h8] = ni_manuf_id_i[7:0];
    q = q + 7'h9;
    if (disc_opt_dev_type_en_i) begin
      for (int j = 0; j < 4; j++) begin
        ni_img[q + 7'(j)] = device_type_identifier_i[31-8*j -: 8];
      end
      q = q + 7'h4;
    end
    if (disc_opt_rssi_en_i) begin
      ni_img[q] = ni_rssi_i;
      q = q + 7'h1;
    end
    ni_len = q;
  end

  always_comb begin
    logic [6:0] dlen;
    logic [6:0] end_pos;
    dlen    = 7'h00;
    end_pos = 7'h00;
    next_r      = r;
    next_r.done = 1'b0;
    unique case (r.state)
      iosnf_pkg::IOSNF_IDLE: begin
        if (take_io || take_ni) begin
          next_r.buf_bytes = take_io ? io_img : ni_img;
          end_pos          = take_io ? io_len : ni_len;
          dlen             = end_pos - iosnf_pkg::OFS_TYPE;
          next_r.buf_bytes[0] = iosnf_pkg::START_DELIM;
          next_r.buf_bytes[iosnf_pkg::OFS_LEN_MSB]       = 8'h00;
          next_r.buf_bytes[iosnf_pkg::OFS_LEN_MSB + 7'h1] = {1'b0, dlen};
          next_r.last    = end_pos - 7'h1;
          next_r.idx     = 7'h00;
          next_r.sum     = 8'h00;
          next_r.tx_data = iosnf_pkg::START_DELIM;
          next_r.state   = iosnf_pkg::IOSNF_HEAD;
        end
      end
      iosnf_pkg::IOSNF_HEAD,
      iosnf_pkg::IOSNF_BODY: begin
        if (tx_ready_i) begin
          if (r.state == iosnf_pkg::IOSNF_BODY) begin
            next_r.sum = r.sum + r.tx_data;
          end
          if (r.idx == r.last) begin
            next_r.tx_data = iosnf_pkg::CSUM_BASE - (r.sum + r.tx_data);
            next_r.state   = iosnf_pkg::IOSNF_CSUM;
          end else begin
            next_r.idx     = r.idx + 7'h1;
            next_r.tx_data = r.buf_bytes[r.idx + 7'h1];
            // sum only from the type byte onward
            if (r.idx + 7'h1 == iosnf_pkg::OFS_TYPE) begin
              next_r.state = iosnf_pkg::IOSNF_BODY;
            end
          end
        end
      end
      iosnf_pkg::IOSNF_CSUM: begin
        if (tx_ready_i) begin
          next_r.done  = 1'b1;
          next_r.state = iosnf_pkg::IOSNF_IDLE;
        end
      end
      default: begin
        next_r.state = iosnf_pkg::IOSNF_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tx_valid_o   = (r.state != iosnf_pkg::IOSNF_IDLE);
  assign tx_data_o    = r.tx_data;
  assign busy_o       = (r.state != iosnf_pkg::IOSNF_IDLE);
  assign frame_done_o = r.done;

endmodule : iosnf_emitter

// [dv/iosnf_host_model.sv]
// host-side byte sink for the frame emitter stream
// assumes one clock; stall_i makes ready alternate every cycle
`timescale 1ns/1ps
module iosnf_host_model (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  // stream
  input  wire logic       stall_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] q[$];
  always @(posedge core_clk_i) begin
    tx_ready_o <= srst_i ? 1'b0 : (stall_i ? ~tx_ready_o : 1'b1);
    // bytes kept raw; option bits beyond the known ones are left uninterpreted
    if (tx_valid_i && tx_ready_o) q.push_back(tx_data_i);
  end
  // csum_ok reports whether data plus checksum sums to ff; no frame is dropped
  function automatic logic csum_ok;
    logic [7:0] s;
    s = 8'h00;
    for (int i = 3; i < q.size(); i++) s += q[i];
    return s == 8'hff;
  endfunction : csum_ok
endmodule : iosnf_host_model

// [dv/iosnf_monitor.sv]
// port checker for the frame emitter
// assumes it is bound onto iosnf_emitter
`timescale 1ns/1ps
module iosnf_monitor (
  input wire logic       core_clk_i,
  input wire logic       srst_i,
  input wire logic       api_output_format_select_i,
  input wire logic       io_ack_o,
  input wire logic       ni_ack_o,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_ready_i,
  input wire logic       busy_o,
  input wire logic       frame_done_o
);
  logic [6:0] cnt;
  logic [7:0] len;
  logic [7:0] sum;
  logic       kind;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // byte index within the frame, restarted by each accepted request
  always_ff @(posedge core_clk_i) begin
    if (srst_i || io_ack_o || ni_ack_o) begin
      cnt <= 7'h00;
      sum <= 8'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      cnt <= cnt + 7'h01;
      if (cnt >= 7'h03) sum <= sum + tx_data_o;
      if (cnt == 7'h02) len <= tx_data_o;
    end
    if (io_ack_o || ni_ack_o) kind <= ni_ack_o;
  end
  a_ack_start: assert property ((io_ack_o || ni_ack_o) |=> tx_valid_o &&
    tx_data_o == iosnf_pkg::START_DELIM) else $error("frame does not open with delimiter");
  a_io_format: assert property (io_ack_o |-> api_output_format_select_i)
    else $error("sample frame taken in standard format");
  a_ni_format: assert property (ni_ack_o |-> !api_output_format_select_i)
    else $error("node frame taken in explicit format");
  a_byte_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
    $stable(tx_data_o)) else $error("byte changed while stalled");
  a_busy_refuse: assert property (busy_o |-> !io_ack_o && !ni_ack_o)
    else $error("request taken while busy");
  a_done_after: assert property (frame_done_o |-> !tx_valid_o &&
    $past(tx_valid_o && tx_ready_i)) else $error("done without final byte");
  a_len_high: assert property (tx_valid_o && cnt == 7'h01 |-> tx_data_o == 8'h00)
    else $error("length high byte not zero");
  a_type_byte: assert property (tx_valid_o && cnt == 7'h03 |->
    tx_data_o == (kind ? 8'h95 : 8'h92)) else $error("wrong frame type");
  a_nsets_one: assert property (tx_valid_o && !kind && cnt == 7'h0f |->
    tx_data_o == 8'h01) else $error("sample set count not one");
  a_csum_byte: assert property (tx_valid_o && cnt > 7'h03 && cnt == len[6:0] + 7'h03 |->
    tx_data_o == 8'hff - sum) else $error("bad checksum byte");
endmodule : iosnf_monitor
bind iosnf_emitter iosnf_monitor iosnf_monitor_i (.core_clk_i, .srst_i,
  .api_output_format_select_i, .io_ack_o, .ni_ack_o, .tx_valid_o, .tx_data_o, .tx_ready_i,
  .busy_o, .frame_done_o);

// [dv/tb_top.sv]
// self-checking bench for the frame emitter
// assumes the host model sinks and records every byte
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 0, srst_i = 1, api_output_format_select_i = 1, stall = 0;
  logic disc_opt_dev_type_en_i = 0, disc_opt_rssi_en_i = 0, io_req_i = 0, ni_req_i = 0;
  logic [63:0] io_src_addr64_i = 0, ni_src_addr64_i = 0, ni_remote_addr64_i = 0;
  logic [15:0] io_src_net16_i = 0, io_digital_io_line_mask_i = 0, io_digital_samples_i = 0;
  logic [15:0] ni_profile_id_i = 0, ni_manuf_id_i = 0;
  logic [7:0] io_rx_opts_i = 0, io_analog_mask_i = 0, ni_rx_opts_i = 0, ni_dev_type_i = 0;
  logic [7:0] ni_src_event_i = 0, ni_rssi_i = 0, tx_data_o, exp[$];
  logic [79:0] io_analog_samples_i = 0;
  logic [159:0] node_identifier_text_i = {8'h41, 8'h42, 144'h0};
  logic [4:0] ni_text_len_i = 5'h02;
  logic [31:0] device_type_identifier_i = 32'h000c0000;
  logic io_ack_o, ni_ack_o, tx_valid_o, tx_ready_i, busy_o, frame_done_o;
  int bad_count = 0, n_compared = 0, cyc = 0;
  always #20 core_clk_i = ~core_clk_i;
  iosnf_emitter iosnf_emitter_i (.core_clk_i, .srst_i, .api_output_format_select_i,
    .disc_opt_dev_type_en_i, .disc_opt_rssi_en_i, .io_req_i, .io_ack_o, .io_src_addr64_i,
    .io_src_net16_i, .io_rx_opts_i, .io_digital_io_line_mask_i, .io_analog_mask_i,
    .io_digital_samples_i, .io_analog_samples_i, .ni_req_i, .ni_ack_o, .ni_src_addr64_i,
    .ni_rx_opts_i, .ni_remote_addr64_i, .node_identifier_text_i, .ni_text_len_i,
    .ni_dev_type_i, .ni_src_event_i, .ni_profile_id_i, .ni_manuf_id_i,
    .device_type_identifier_i, .ni_rssi_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .busy_o,
    .frame_done_o);
  iosnf_host_model iosnf_host_model_i (.core_clk_i, .srst_i, .stall_i(stall),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
  task chk(input logic [15:0] got, input logic [15:0] want);
    n_compared++;
    if (got !== want) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task put(input logic [7:0] b);
    exp.push_back(b);
  endtask : put
  task put16(input logic [15:0] v);
    put(v[15:8]);
    put(v[7:0]);
  endtask : put16
  task put64(input logic [63:0] v);
    for (int i = 7; i >= 0; i--) put(v[8*i+:8]);
  endtask : put64
  // close the expected frame, then request it and compare what the host got
  task run(input logic is_io);
    logic [7:0] s;
    int n;
    s = 8'h00;
    exp[2] = 8'(exp.size() - 3);
    for (int i = 3; i < exp.size(); i++) s += exp[i];
    put(8'hff - s);
    if (is_io) io_req_i = 1'b1;
    else ni_req_i = 1'b1;
    #5;
    for (n = 0; n < 50 && (io_ack_o | ni_ack_o) !== 1'b1; n++) @(negedge core_clk_i) #5;
    @(negedge core_clk_i);
    chk(busy_o, 1'b1);
    chk(io_ack_o | ni_ack_o, 1'b0);
    chk(tx_data_o, 8'h7e);
    io_req_i = 1'b0;
    ni_req_i = 1'b0;
    for (n = 0; n < 2000 && frame_done_o !== 1'b1; n++) @(negedge core_clk_i);
    chk(frame_done_o, 1'b1);
    chk(busy_o, 1'b0);
    chk(16'(iosnf_host_model_i.q.size()), 16'(exp.size()));
    foreach (exp[i]) chk(iosnf_host_model_i.q[i], exp[i]);
    chk(iosnf_host_model_i.csum_ok(), 1'b1);
    iosnf_host_model_i.q.delete();
    $display("frame test done, %0d bytes", exp.size());
  endtask : run
  task io_frame(input logic [15:0] dm, input logic [7:0] am, input logic [7:0] op);
    io_digital_io_line_mask_i = dm;
    io_analog_mask_i = am;
    io_rx_opts_i = op;
    exp = {8'h7e, 8'h00, 8'h00, 8'h92};
    put64(io_src_addr64_i);
    put16(io_src_net16_i);
    put(op & 8'h03);
    put(8'h01);
    put16(dm);
    put(am);
    if (dm != 16'h0000) put16(io_digital_samples_i & dm);
    for (int c = 0; c < 5; c++) if (am[c == 4 ? 7 : c]) put16(io_analog_samples_i[16*c+:16]);
    run(1'b1);
  endtask : io_frame
  task ni_frame(input logic dd, input logic rs, input logic [7:0] dt);
    disc_opt_dev_type_en_i = dd;
    disc_opt_rssi_en_i = rs;
    ni_dev_type_i = dt;
    exp = {8'h7e, 8'h00, 8'h00, 8'h95};
    put64(ni_src_addr64_i);
    put16(16'hfffe);
    put(ni_rx_opts_i & 8'hc3);
    put16(16'hfffe);
    put64(ni_remote_addr64_i);
    for (int k = 0; k < ni_text_len_i && node_identifier_text_i[159-8*k-:8] != 8'h00; k++)
      put(node_identifier_text_i[159-8*k-:8]);
    put(8'h00);
    put16(16'hfffe);
    put(dt);
    put(ni_src_event_i);
    put16(ni_profile_id_i);
    put16(ni_manuf_id_i);
    if (dd) put16(device_type_identifier_i[31:16]);
    if (dd) put16(device_type_identifier_i[15:0]);
    if (rs) put(ni_rssi_i);
    run(1'b0);
  endtask : ni_frame
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(negedge core_clk_i);
    srst_i = 1'b0;
    io_src_addr64_i = 64'h0013a20040522baa;
    io_src_net16_i = 16'hfffe;
    io_digital_samples_i = 16'hfff4;
    io_analog_samples_i = {16'h0bbb, 16'h0333, 16'h0222, 16'h0225, 16'h0111};
    io_frame(16'h001c, 8'h02, 8'h01);
    stall = 1'b1;
    ni_req_i = 1'b1;
    repeat (5) @(negedge core_clk_i);
    chk(ni_ack_o, 1'b0);
    chk(tx_valid_o, 1'b0);
    ni_req_i = 1'b0;
    $display("wrong format test done");
    io_frame(16'h0000, 8'h89, 8'hfe);
    api_output_format_select_i = 1'b0;
    ni_src_addr64_i = 64'h0013a200407402ac;
    ni_remote_addr64_i = 64'h0013a20011223344;
    ni_rx_opts_i = 8'hff;
    ni_src_event_i = 8'h01;
    ni_profile_id_i = 16'hc105;
    ni_manuf_id_i = 16'h101e;
    ni_rssi_i = 8'h2e;
    for (int i = 0; i < 4; i++) ni_frame(i[0], i[1], 8'(i % 3));
    // longest identifier text with both optional fields uses 59 of the 64 frame buffer bytes
    node_identifier_text_i = {20{8'h5a}};
    ni_text_len_i = 5'h14;
    ni_frame(1'b1, 1'b1, 8'h01);
    // an embedded zero ends the text before the given length
    node_identifier_text_i = {8'h43, 8'h00, 144'h5a};
    ni_text_len_i = 5'h05;
    ni_frame(1'b0, 1'b0, 8'h02);
    give_verdict();
  end
endmodule : tb_top
